// ---- hcr_device.sv ----
// Device end: the hardware configuration register with soft reset sequencing
`timescale 1ns/10ps
`default_nettype none
module hcr_device
  import hcr_pkg::*;
#(
  parameter int TIMEOUT_CYC = HCR_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  hcr_if.dev bus,
  input wire logic strap_i,
  input wire logic phy_clk_run_i,
  input wire logic tx_err_i,
  input wire logic rx_err_i,
  output logic port_path_byte_order_o,
  output logic direct_path_byte_order_o,
  output logic must_set_bit_o,
  output logic [3:0] transmit_buffer_size_o,
  output logic [14:0] tx_data_bytes_o,
  output logic [14:0] tx_status_bytes_o,
  output logic [14:0] rx_total_bytes_o,
  output logic soft_reset_pulse_o,
  output logic tx_err_o,
  output logic rx_err_o
);
  typedef enum logic [1:0] {HCR_IDLE, HCR_SOFTWARE_RESET_REQUEST_WAIT} hcr_state_t;

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] strap_sync, run_sync;
  logic strap_done;
  logic strap_val;
  logic port_end, direct_end, must_set, timeout_flag;
  logic [3:0] size;
  logic ack, tx_err, rx_err, software_reset_request_pulse;
  logic [31:0] rdata;
  logic [14:0] tx_data_b, tx_stat_b, rx_b;
  hcr_state_t state;
  logic [$clog2(TIMEOUT_CYC+1)-1:0] cnt;

  logic next_strap_done, next_strap_val;
  logic next_port_end, next_direct_end, next_must_set, next_timeout_flag;
  logic [3:0] next_size;
  logic next_ack, next_tx_err, next_rx_err, next_software_reset_request_pulse;
  logic [31:0] next_rdata;
  hcr_state_t next_state;
  logic [$clog2(TIMEOUT_CYC+1)-1:0] next_cnt;

  wire logic sel = bus.req && !ack && bus.addr == HCR_CFG_OFS;
  wire logic wr_hit = sel && bus.wr;
  logic run_ok, strap_lvl;
  logic next_run_ok, next_strap_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Pin filters: a level counts only once the last two stages agree, so an
  // edge caught mid-transition never reaches the reset sequencer or the strap
  always_comb begin
    next_run_ok = run_ok;
    next_strap_lvl = strap_lvl;
    if (run_sync[2] == run_sync[1]) begin
      next_run_ok = run_sync[2];
    end
    if (strap_sync[2] == strap_sync[1]) begin
      next_strap_lvl = strap_sync[2];
    end
  end

  always_ff @(posedge clk_i) begin
    strap_sync <= {strap_sync[1:0], strap_i};
    run_sync <= {run_sync[1:0], phy_clk_run_i};
    run_ok <= next_run_ok;
    strap_lvl <= next_strap_lvl;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_strap_done = 1'b1;
    next_strap_val = strap_done ? strap_val : strap_lvl;
    next_port_end = port_end;
    next_direct_end = direct_end;
    next_must_set = must_set;
    next_size = size;
    next_timeout_flag = timeout_flag;
    next_state = state;
    next_cnt = cnt;
    next_software_reset_request_pulse = 1'b0;
    next_tx_err = tx_err | tx_err_i;
    next_rx_err = rx_err | rx_err_i;
    if (wr_hit) begin
      next_port_end = bus.wdata[HCR_PORT_END_BIT];
      next_direct_end = bus.wdata[HCR_DIRECT_END_BIT];
      next_must_set = bus.wdata[HCR_MUST_SET_BIT];
      next_size = bus.wdata[HCR_SIZE_LSB +: 4];
      if (bus.wdata[HCR_SOFTWARE_RESET_REQUEST_BIT] && state == HCR_IDLE) begin
        next_state = HCR_SOFTWARE_RESET_REQUEST_WAIT;
        next_cnt = '0;
        next_timeout_flag = 1'b0;
      end
    end
    unique case (state)
      HCR_IDLE: begin
      end
      HCR_SOFTWARE_RESET_REQUEST_WAIT: begin
        if (run_ok) begin
          // Endian bits are immune; everything else returns to default
          next_state = HCR_IDLE;
          next_must_set = 1'b0;
          next_size = HCR_SIZE_RST;
          // An error arriving in this same cycle still latches
          next_tx_err = tx_err_i;
          next_rx_err = rx_err_i;
          next_software_reset_request_pulse = 1'b1;
        end else if (cnt == ($bits(cnt))'(TIMEOUT_CYC - 1)) begin
          next_state = HCR_IDLE;
          next_timeout_flag = 1'b1;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    endcase
  end

  // Size arithmetic: TX status fixed, RX gets the rest of the shared buffer
  always_comb begin
    tx_stat_b = 15'(HCR_TXS_BYTES);
    tx_data_b = 15'(size * HCR_KB) - tx_stat_b;
    rx_b = 15'(HCR_BUF_BYTES - size * HCR_KB);
  end

  // Sizes trail the field by one cycle, keeping the arithmetic off the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_bytes_o <= 15'h0000;
      tx_status_bytes_o <= 15'h0000;
      rx_total_bytes_o <= 15'h0000;
    end else begin
      tx_data_bytes_o <= tx_data_b;
      tx_status_bytes_o <= tx_stat_b;
      rx_total_bytes_o <= rx_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port: ack one cycle after the take, read data only beside it
  always_comb begin
    next_ack = bus.req && !ack;
    next_rdata = 32'h0000_0000;
    if (sel && !bus.wr) begin
      next_rdata[HCR_PORT_END_BIT] = port_end;
      next_rdata[HCR_DIRECT_END_BIT] = direct_end;
      next_rdata[HCR_STRAP_BIT] = strap_val;
      next_rdata[HCR_MUST_SET_BIT] = must_set;
      next_rdata[HCR_SIZE_LSB +: 4] = size;
      next_rdata[HCR_TIMEOUT_BIT] = timeout_flag;
      // Request bit reads one until the reset has completed or given up
      next_rdata[HCR_SOFTWARE_RESET_REQUEST_BIT] = (state == HCR_SOFTWARE_RESET_REQUEST_WAIT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done <= 1'b0;
      strap_val <= 1'b0;
      port_end <= 1'b0;
      direct_end <= 1'b0;
      must_set <= 1'b0;
      size <= HCR_SIZE_RST;
      timeout_flag <= 1'b0;
      state <= HCR_IDLE;
      cnt <= '0;
      software_reset_request_pulse <= 1'b0;
      tx_err <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      strap_done <= next_strap_done;
      strap_val <= next_strap_val;
      port_end <= next_port_end;
      direct_end <= next_direct_end;
      must_set <= next_must_set;
      size <= next_size;
      timeout_flag <= next_timeout_flag;
      state <= next_state;
      cnt <= next_cnt;
      software_reset_request_pulse <= next_software_reset_request_pulse;
      tx_err <= next_tx_err;
      rx_err <= next_rx_err;
    end
  end

  assign bus.ack = ack;
  assign bus.rdata = rdata;
  assign port_path_byte_order_o = port_end;
  assign direct_path_byte_order_o = direct_end;
  assign must_set_bit_o = must_set;
  assign transmit_buffer_size_o = size;
  assign soft_reset_pulse_o = software_reset_request_pulse;
  assign tx_err_o = tx_err;
  assign rx_err_o = rx_err;
endmodule
`default_nettype wire

// ---- hcr_pkg.sv ----
// Package: constants shared by both ends of the hardware configuration link
// Functional notes
// - Host halts TX and RX before writing.
// - Bit 29 sets port path byte order.
// - Bit 28 sets direct path byte order.
// - Soft reset spares immune endian bits.
// - Bit 0 self-clearing soft reset, clears errors.
// - Bit 24 reads sampled crossover strap.
// - Host must set bit 20 to one.
// - Bits 19:16 TX size, 1KB steps, reset 5.
// - TX status takes fixed 512 bytes.
// - Host never programs TX size below 2KB.
// - RX gets 16KB minus TX allocation.
// - Reset without PHY clocks times out, bit 1.
// - After timeout, wake PHY then retry reset.
package hcr_pkg;
  localparam logic [7:0] HCR_CFG_OFS = 8'h74;
  localparam int HCR_PORT_END_BIT = 29;
  localparam int HCR_DIRECT_END_BIT = 28;
  localparam int HCR_STRAP_BIT = 24;
  localparam int HCR_MUST_SET_BIT = 20;
  localparam int HCR_SIZE_LSB = 16;
  localparam int HCR_TIMEOUT_BIT = 1;
  localparam int HCR_SOFTWARE_RESET_REQUEST_BIT = 0;
  localparam logic [3:0] HCR_SIZE_RST = 4'h5;
  localparam logic [3:0] HCR_SIZE_MIN = 4'h2;
  localparam logic [3:0] HCR_SIZE_MAX = 4'he;
  localparam logic [31:0] HCR_WR_MASK = 32'h301f_0001;
  localparam int HCR_BUF_BYTES = 16384;
  localparam int HCR_KB = 1024;
  localparam int HCR_TXS_BYTES = 512;
  localparam int HCR_TIMEOUT_NS = 100000;
  localparam int HCR_CLK_NS = 100;
  localparam int HCR_TIMEOUT_CYC = HCR_TIMEOUT_NS / HCR_CLK_NS;
  localparam int HCR_RST_NS = 1000;
  localparam int HCR_RST_CYC = HCR_RST_NS / HCR_CLK_NS;
  localparam logic [3:0] HCR_WB_CTRL = 4'h0;
  localparam logic [3:0] HCR_WB_WDATA = 4'h4;
  localparam logic [3:0] HCR_WB_RDATA = 4'h8;
  localparam logic [3:0] HCR_WB_STAT = 4'hc;
  localparam logic [3:0] HCR_WB_MASK = 4'hd;
  localparam logic [4:0] HCR_ST_DONE = 5'h01;
  localparam logic [4:0] HCR_ST_TO = 5'h02;
  localparam logic [4:0] HCR_ST_SOFTWARE_RESET_REQUEST_OK = 5'h04;
  localparam logic [4:0] HCR_ST_REFUSED = 5'h08;
  localparam logic [4:0] HCR_ST_BADSIZE = 5'h10;
endpackage

// ---- hcr_if.sv ----
// Interface: host register port between the configuration register and its host
`timescale 1ns/10ps
`default_nettype none
interface hcr_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// ---- hcr_host.sv ----
// Host end: Wishbone-controlled master that drives the configuration register port
`timescale 1ns/10ps
`default_nettype none
module hcr_host
  import hcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic tx_halted_i,
  input wire logic rx_halted_i,
  hcr_if.host link
);
  typedef enum logic [1:0] {HH_IDLE, HH_WAIT, HH_POLL, HH_PWAIT} hh_state_t;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl, wdat, rdat, dat_o;
  logic [4:0] stat, mask;
  logic ack_o, irq, req, wr;
  logic [31:0] lwdata;
  hh_state_t state;
  logic [31:0] next_ctrl, next_wdat, next_rdat, next_dat_o, next_lwdata;
  logic [4:0] next_stat, next_mask, ev;
  logic next_ack_o, next_req, next_wr;
  hh_state_t next_state;

  wire logic wb_hit = wb_cyc_i && wb_stb_i && !ack_o;
  wire logic busy = state != HH_IDLE;

  // Byte-lane merge used by the control and write data words; the mask takes bits 4:0 whole
  function automatic logic [31:0] hh_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_ctrl = ctrl;
    next_wdat = wdat;
    next_rdat = rdat;
    next_mask = mask;
    next_state = state;
    next_req = req;
    next_wr = wr;
    next_lwdata = lwdata;
    next_ack_o = wb_hit;
    next_dat_o = 32'h0000_0000;
    ev = 5'h00;
    unique case (state)
      HH_IDLE: begin
        if (ctrl[0]) begin
          next_ctrl[0] = 1'b0;
          if (ctrl[1] && !(tx_halted_i && rx_halted_i)) begin
            ev = ev | HCR_ST_REFUSED;
          end else if (ctrl[1] && wdat[HCR_SIZE_LSB +: 4] < HCR_SIZE_MIN) begin
            ev = ev | HCR_ST_BADSIZE;
          end else if (ctrl[1] && wdat[HCR_SIZE_LSB +: 4] > HCR_SIZE_MAX) begin
            ev = ev | HCR_ST_BADSIZE;
          end else begin
            next_req = 1'b1;
            next_wr = ctrl[1];
            // Must-set bit forced on so normal operation is never lost
            next_lwdata = (wdat & HCR_WR_MASK) | (32'h1 << HCR_MUST_SET_BIT);
            next_state = HH_WAIT;
          end
        end
      end
      HH_WAIT: begin
        if (link.ack) begin
          next_req = 1'b0;
          if (!wr) next_rdat = link.rdata;
          if (wr && lwdata[HCR_SOFTWARE_RESET_REQUEST_BIT]) begin
            next_state = HH_POLL;
          end else begin
            next_state = HH_IDLE;
            ev = ev | HCR_ST_DONE;
          end
        end
      end
      // Re-read until the request bit clears: the reset has then ended one way
      HH_POLL: begin
        next_req = 1'b1;
        next_wr = 1'b0;
        next_lwdata = 32'h0000_0000;
        next_state = HH_PWAIT;
      end
      HH_PWAIT: begin
        if (link.ack) begin
          next_req = 1'b0;
          next_rdat = link.rdata;
          if (!link.rdata[HCR_SOFTWARE_RESET_REQUEST_BIT]) begin
            next_state = HH_IDLE;
            ev = ev | HCR_ST_DONE;
            // Timeout means the PHY must be woken before a retry
            if (link.rdata[HCR_TIMEOUT_BIT]) ev = ev | HCR_ST_TO;
            else ev = ev | HCR_ST_SOFTWARE_RESET_REQUEST_OK;
          end else begin
            next_state = HH_POLL;
          end
        end
      end
    endcase
    next_stat = stat | ev;
    if (wb_hit) begin
      unique case (wb_adr_i)
        HCR_WB_CTRL: if (wb_we_i && !busy) next_ctrl = hh_merge(ctrl, wb_dat_i, wb_sel_i);
        HCR_WB_WDATA: if (wb_we_i) next_wdat = hh_merge(wdat, wb_dat_i, wb_sel_i);
        HCR_WB_MASK: if (wb_we_i) next_mask = wb_dat_i[4:0];
        default: ;
      endcase
      if (!wb_we_i) begin
        unique case (wb_adr_i)
          HCR_WB_CTRL: next_dat_o = {30'h0, busy, ctrl[1]};
          HCR_WB_WDATA: next_dat_o = wdat;
          HCR_WB_RDATA: next_dat_o = rdat;
          HCR_WB_STAT: next_dat_o = {27'h0, stat};
          HCR_WB_MASK: next_dat_o = {27'h0, mask};
          default: next_dat_o = 32'h0000_0000;
        endcase
        // Read clears status, but an event in the same cycle survives
        if (wb_adr_i == HCR_WB_STAT) next_stat = ev;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 32'h0000_0000;
      wdat <= 32'h0000_0000;
      rdat <= 32'h0000_0000;
      stat <= 5'h00;
      mask <= 5'h00;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq <= 1'b0;
      req <= 1'b0;
      wr <= 1'b0;
      lwdata <= 32'h0000_0000;
      state <= HH_IDLE;
    end else begin
      ctrl <= next_ctrl;
      wdat <= next_wdat;
      rdat <= next_rdat;
      stat <= next_stat;
      mask <= next_mask;
      ack_o <= next_ack_o;
      dat_o <= next_dat_o;
      irq <= |(next_stat & next_mask);
      req <= next_req;
      wr <= next_wr;
      lwdata <= next_lwdata;
      state <= next_state;
    end
  end

  assign wb_ack_o = ack_o;
  assign wb_dat_o = dat_o;
  assign irq_o = irq;
  assign link.req = req;
  assign link.wr = wr;
  assign link.addr = HCR_CFG_OFS;
  assign link.wdata = lwdata;
endmodule
`default_nettype wire

// ---- hcr_link_properties.sv ----
// Checker: handshake and register image properties of the configuration link
`timescale 1ns/10ps
`default_nettype none
module hcr_link_properties
  import hcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Device answers exactly one cycle after it takes a request
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  // Host must not move the word while the device is still taking it
  property p_req_hold; req && !ack |=> req && $stable(wdata) && $stable(wr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not dropped after ack");
  property p_addr; req |-> addr == HCR_CFG_OFS; endproperty
  a_addr: assert property (p_addr) else $error("wrong register offset");
  property p_rd_idle; !ack |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
  ////////////////////////////////////////////////////////////////////////////////////////////
  property p_rsvd_rd; ack && !wr |-> (rdata & 32'hcee0_fffc) == 32'h0; endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bit read as one");
  property p_rsvd_wr; req && wr |-> (wdata & ~HCR_WR_MASK) == 32'h0; endproperty
  a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved bit written");
  property p_mbo; req && wr |-> wdata[HCR_MUST_SET_BIT]; endproperty
  a_mbo: assert property (p_mbo) else $error("must set bit written zero");
  property p_size; req && wr |-> wdata[19:16] inside {[HCR_SIZE_MIN:HCR_SIZE_MAX]}; endproperty
  a_size: assert property (p_size) else $error("size outside range written");
endmodule
`default_nettype wire

// ---- test_hardware_config_register.sv ----
// Testbench: both ends of the configuration link, driven over Wishbone
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_hardware_config_register
  import hcr_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ia, ib, ep, ed;
  logic txh = 1'b1, rxh = 1'b1, strap = 1'b1, run = 1'b1, txe_i = 1'b0, rxe_i = 1'b0;
  logic [3:0] adr = 4'h0, sz, es = 4'h5, sel = 4'hf;
  logic [31:0] dat = 32'h0, q, wdo;
  logic ack, irq, pe, de, must_set_bit, srp, txe, rxe;
  logic [14:0] txd, txs, rxt;
  int err_total = 0, checks_done = 0, cycles = 0, pulses = 0;
  // Ordinary rows: expected refusal bits beside the word written
  logic [36:0] rows [5] = '{{5'h00, 32'h3006_0000}, {5'h00, 32'hcfe2_fffe},
    {5'h00, 32'h200e_0000}, {5'h10, 32'h0001_0000}, {5'h10, 32'h000f_0000}};
  hcr_if lnk();
  hcr_device #(.TIMEOUT_CYC(8)) u_hcr_device (.clk_i(clk_i), .rst_i(rst_i), .bus(lnk),
    .strap_i(strap), .phy_clk_run_i(run), .tx_err_i(txe_i), .rx_err_i(rxe_i),
    .port_path_byte_order_o(pe), .direct_path_byte_order_o(de), .must_set_bit_o(must_set_bit),
    .transmit_buffer_size_o(sz), .tx_data_bytes_o(txd), .tx_status_bytes_o(txs),
    .rx_total_bytes_o(rxt), .soft_reset_pulse_o(srp), .tx_err_o(txe), .rx_err_o(rxe));
  hcr_host u_hcr_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wdo),
    .wb_ack_o(ack), .irq_o(irq), .tx_halted_i(txh), .rx_halted_i(rxh), .link(lnk));
  hcr_link_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (srp === 1'b1) pulses++;
    if (cycles == 6000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Entered right after a rising edge; the result lands in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Busy may lag the go bit, so the poll starts a little later
  task automatic op(input logic w, input logic [31:0] d);
    wb(1'b1, HCR_WB_WDATA, d);
    wb(1'b1, HCR_WB_CTRL, {30'h0, w, 1'b1});
    repeat (2) @(posedge clk_i);
    q = 32'h2;
    while (q[1] !== 1'b0) wb(1'b0, HCR_WB_CTRL, 32'h0);
  endtask
  task automatic readback();
    op(1'b0, 32'h0);
    wb(1'b0, HCR_WB_RDATA, 32'h0);
  endtask
  task automatic chk_cfg(input logic [3:0] s, input logic p, input logic d);
    `CHK("size", s, sz)
    `CHK("port order", p, pe)
    `CHK("direct order", d, de)
    `CHK("tx data", 15'(s * 1024 - 512), txd)
    `CHK("tx status", 15'h200, txs)
    `CHK("rx total", 15'(16384 - s * 1024), rxt)
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    ep = 1'b0;
    ed = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Byte counts are registered one edge behind the size field
    repeat (2) @(posedge clk_i);
    chk_cfg(4'h5, 1'b0, 1'b0);
    `CHK("mbo reset", 1'b0, must_set_bit)
    `CHK("irq reset", 1'b0, irq)
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      op(1'b1, rows[i][31:0]);
      wb(1'b0, HCR_WB_STAT, 32'h0);
      `CHK("refusal", rows[i][36:32], q[4:0] & 5'h18)
      if (rows[i][36:32] == 5'h0) begin
        es = rows[i][19:16];
        ep = rows[i][29];
        ed = rows[i][28];
      end
      chk_cfg(es, ep, ed);
      readback();
      `CHK("image", {2'h0, ep, ed, 3'h0, strap, 4'h1, es, 16'h0}, q)
    end
    `CHK("strap", 1'b1, q[24])
    `CHK("mbo set", 1'b1, must_set_bit)
    sel <= 4'h1;
    wb(1'b1, HCR_WB_WDATA, 32'hffff_ffff);
    sel <= 4'hf;
    wb(1'b0, HCR_WB_WDATA, 32'h0);
    `CHK("byte lane", 32'h0000_00ff, q)
    $display("row test done");
    op(1'b1, 32'h200e_0000);
    wb(1'b1, HCR_WB_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    ia = irq;
    wb(1'b1, HCR_WB_MASK, 32'h1f);
    repeat (2) @(posedge clk_i);
    ib = irq;
    `CHK("irq masked", 1'b0, ia)
    `CHK("irq unmasked", 1'b1, ib)
    wb(1'b0, HCR_WB_STAT, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq)
    $display("interrupt test done");
    txh <= 1'b0;
    op(1'b1, 32'h3006_0000);
    wb(1'b0, HCR_WB_STAT, 32'h0);
    `CHK("not halted", 5'h08, q[4:0] & 5'h08)
    chk_cfg(es, ep, ed);
    txh <= 1'b1;
    txe_i <= 1'b1;
    rxe_i <= 1'b1;
    @(posedge clk_i);
    txe_i <= 1'b0;
    rxe_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("tx err", 1'b1, txe)
    `CHK("rx err", 1'b1, rxe)
    $display("refusal test done");
    // Stopped PHY clocks must make the reset give up, not complete
    run <= 1'b0;
    repeat (4) @(posedge clk_i);
    op(1'b1, 32'h200e_0001);
    wb(1'b0, HCR_WB_STAT, 32'h0);
    `CHK("timeout", 5'h02, q[4:0] & 5'h06)
    `CHK("no pulse", 0, pulses)
    readback();
    `CHK("timeout bit", 1'b1, q[1])
    run <= 1'b1;
    repeat (4) @(posedge clk_i);
    op(1'b1, 32'h200e_0001);
    wb(1'b0, HCR_WB_STAT, 32'h0);
    `CHK("reset ok", 5'h04, q[4:0] & 5'h06)
    `CHK("pulse", 1, pulses)
    `CHK("tx err clr", 1'b0, txe)
    `CHK("rx err clr", 1'b0, rxe)
    `CHK("mbo clr", 1'b0, must_set_bit)
    chk_cfg(4'h5, ep, ed);
    readback();
    `CHK("image", {2'h0, ep, ed, 3'h0, strap, 8'h05, 16'h0}, q)
    $display("soft reset test done");
    complete_run();
  end
endmodule
`default_nettype wire
